// ### pkg/itcd_pkg.sv
// How it works
// - First four control-byte bits must equal the configured control code to respond.
// - Next three control-byte bits are the block address, top of the pointer.
// - Last control-byte bit: one means read, zero means write.
// - Device acknowledges a matching control byte on the data line.
// - Pointer loads from block address above the received word address.
// - In a byte write the master then sends one data byte for the pointer.
// - Device acknowledges the data byte; master then sends a stop.
// - Data byte is stored on the rising edge that ends its last bit, before the acknowledge is driven, not at the stop.
// - Repeated start after the word address drops the write but keeps the pointer.
// - After a read control byte the device acknowledges, then shifts out the byte.
// - Default seven-bit target address is 08 hexadecimal.
// - Block 000 is volatile and returns to programmed values after reset.
// - Block 010 holds the programmed nonvolatile configuration.
package itcd_pkg;

  localparam int CODE_BITS = 4;
  localparam int BLOCK_BITS = 3;
  localparam int WORD_BITS = 8;
  localparam int PTR_BITS = BLOCK_BITS + WORD_BITS;
  localparam int WORDS = 1 << WORD_BITS;

  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  localparam int BLOCK_MSB = 3;
  localparam int BLOCK_LSB = 1;
  localparam int DIR_POS = 0;

  localparam logic [CODE_BITS-1:0] CTRL_CODE_DEFAULT = 4'h1;
  localparam logic [BLOCK_BITS-1:0] BLOCK_VOLATILE = 3'h0;
  localparam logic [BLOCK_BITS-1:0] BLOCK_NVM = 3'h2;
  localparam logic DIR_READ = 1'h1;
  localparam logic ACK_LEVEL = 1'h0;
  localparam logic SDA_DRIVE_LEVEL = 1'h0;
  localparam logic [WORD_BITS-1:0] UNMAPPED_DATA = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT_AFTER_START = 3'h1;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [WORD_BITS-1:0] WORD_STEP = 8'h01;

  typedef enum logic [3:0] {
    ITCD_IDLE = 4'h0,
    ITCD_CTRL = 4'h1,
    ITCD_CTRL_ACK = 4'h2,
    ITCD_WADDR = 4'h3,
    ITCD_WADDR_ACK = 4'h4,
    ITCD_WDATA = 4'h5,
    ITCD_WDATA_ACK = 4'h6,
    ITCD_RDATA = 4'h7,
    ITCD_RACK = 4'h8,
    ITCD_IGNORE = 4'h9
  } itcd_state_t;

endpackage : itcd_pkg

// ### pkg/itcd_store_if.sv
`timescale 1ns/1ps

// Carries the byte store port between the link engine and the storage.
interface itcd_store_if;
  import itcd_pkg::*;

  logic wrEn;
  logic [PTR_BITS-1:0] wrPtr;
  logic [WORD_BITS-1:0] wrData;
  logic [PTR_BITS-1:0] rdPtr;
  logic [WORD_BITS-1:0] rdData;

  modport engine (
    output wrEn,
    output wrPtr,
    output wrData,
    output rdPtr,
    input rdData
  );

  modport store (
    input wrEn,
    input wrPtr,
    input wrData,
    input rdPtr,
    output rdData
  );

endinterface : itcd_store_if

// ### verilog/itcd_store.sv
`timescale 1ns/1ps

module itcd_store (
  input wire logic sclClock,
  input wire logic linkRst_n,
  itcd_store_if.store port
);
  import itcd_pkg::*;

  logic [WORD_BITS-1:0] volatileMem [WORDS];
  logic [WORD_BITS-1:0] nvmMem [WORDS];
  logic [WORDS-1:0] dirty;

  logic [BLOCK_BITS-1:0] wrBlock;
  logic [WORD_BITS-1:0] wrWord;
  logic [BLOCK_BITS-1:0] rdBlock;
  logic [WORD_BITS-1:0] rdWord;

  assign wrBlock = port.wrPtr[PTR_BITS-1:WORD_BITS];
  assign wrWord = port.wrPtr[WORD_BITS-1:0];
  assign rdBlock = port.rdPtr[PTR_BITS-1:WORD_BITS];
  assign rdWord = port.rdPtr[WORD_BITS-1:0];

  // ********************************************************
  // Storage
  // ********************************************************
  // The nonvolatile block has no reset on purpose: it must survive one.
  always_ff @(posedge sclClock) begin
    if (port.wrEn && wrBlock == BLOCK_VOLATILE) begin
      volatileMem[wrWord] <= port.wrData;
    end
    if (port.wrEn && wrBlock == BLOCK_NVM) begin
      nvmMem[wrWord] <= port.wrData;
    end
  end

  // A volatile byte not written since reset reads as its programmed value.
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      dirty <= '0;
    end else if (port.wrEn && wrBlock == BLOCK_VOLATILE) begin
      dirty[wrWord] <= 1'h1;
    end
  end

  always_comb begin
    if (rdBlock == BLOCK_VOLATILE) begin
      port.rdData = dirty[rdWord] ? volatileMem[rdWord] : nvmMem[rdWord];
    end else if (rdBlock == BLOCK_NVM) begin
      port.rdData = nvmMem[rdWord];
    end else begin
      port.rdData = UNMAPPED_DATA;
    end
  end

endmodule : itcd_store

// ### verilog/itcd_top.sv
`timescale 1ns/1ps

module itcd_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclClock,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [itcd_pkg::CODE_BITS-1:0] controlCode,
  output logic commitPulse,
  output logic [itcd_pkg::BLOCK_BITS-1:0] commitBlock,
  output logic [itcd_pkg::WORD_BITS-1:0] commitAddr,
  output logic [itcd_pkg::WORD_BITS-1:0] commitData
);
  import itcd_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [1:0] rstPipe_n;
  logic linkRst_n;

  logic startTog;
  logic stopTog;
  logic startSeen;
  logic stopSeen;
  logic startPending;
  logic stopPending;

  logic [CODE_BITS-1:0] codeMeta;
  logic [CODE_BITS-1:0] codeLink;

  itcd_state_t state;
  itcd_state_t next_state;
  logic [2:0] bitCnt;
  logic [WORD_BITS-1:0] shiftReg;
  logic [WORD_BITS-1:0] rxByte;
  logic lastBit;
  logic ctrlDir;
  logic [PTR_BITS-1:0] ptr;
  logic [WORD_BITS-1:0] txByte;
  logic oeReg;
  logic commitNow;

  logic commitTog;
  logic [PTR_BITS-1:0] holdPtr;
  logic [WORD_BITS-1:0] holdData;
  logic [2:0] commitSync;

  itcd_store_if storeBus ();

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic inByte(input itcd_state_t st);
    inByte = (st == ITCD_CTRL) || (st == ITCD_WADDR) ||
             (st == ITCD_WDATA) || (st == ITCD_RDATA);
  endfunction : inByte

  function automatic logic inAckSlot(input itcd_state_t st);
    inAckSlot = (st == ITCD_CTRL_ACK) || (st == ITCD_WADDR_ACK) ||
                (st == ITCD_WDATA_ACK);
  endfunction : inAckSlot

  function automatic logic codeMatch(
    input logic [WORD_BITS-1:0] ctrlByte,
    input logic [CODE_BITS-1:0] code
  );
    codeMatch = (ctrlByte[CODE_MSB:CODE_LSB] == code);
  endfunction : codeMatch

  // ********************************************************
  // Reset release
  // ********************************************************
  // The link side has no clock of its own between frames, so it takes
  // this synchronised copy as a plain asynchronous reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_n <= 2'h0;
    end else begin
      rstPipe_n <= {rstPipe_n[0], 1'h1};
    end
  end

  assign linkRst_n = rstPipe_n[1];

  // ********************************************************
  // Start and stop detection
  // ********************************************************
  // A start is the data line falling while the bus clock is high, a stop
  // is it rising. Both are caught on data-line edges as toggles, because
  // the bus clock does not run across a stop.
  always_ff @(negedge sdaIn or negedge linkRst_n) begin
    if (!linkRst_n) begin
      startTog <= 1'h0;
    end else if (sclClock) begin
      startTog <= ~startTog;
    end
  end

  always_ff @(posedge sdaIn or negedge linkRst_n) begin
    if (!linkRst_n) begin
      stopTog <= 1'h0;
    end else if (sclClock) begin
      stopTog <= ~stopTog;
    end
  end

  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      startSeen <= 1'h0;
      stopSeen <= 1'h0;
    end else begin
      startSeen <= startTog;
      stopSeen <= stopTog;
    end
  end

  // The toggles settle while the bus clock is held high around the
  // condition, long before the next rising edge samples them.
  assign startPending = startTog ^ startSeen;
  assign stopPending = stopTog ^ stopSeen;

  // ********************************************************
  // Control code into the link domain
  // ********************************************************
  // The code is a static setting; a two-stage capture is enough as long
  // as software does not change it during a transfer.
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      codeMeta <= CTRL_CODE_DEFAULT;
      codeLink <= CTRL_CODE_DEFAULT;
    end else begin
      codeMeta <= controlCode;
      codeLink <= codeMeta;
    end
  end

  // ********************************************************
  // Bit shifter
  // ********************************************************
  assign rxByte = {shiftReg[WORD_BITS-2:0], sdaIn};
  assign lastBit = (bitCnt == LAST_BIT);

  // The rising edge that follows a start already carries the first bit.
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      bitCnt <= 3'h0;
      shiftReg <= '0;
    end else if (startPending) begin
      bitCnt <= FIRST_BIT_AFTER_START;
      shiftReg <= {{(WORD_BITS-1){1'h0}}, sdaIn};
    end else if (inByte(state)) begin
      bitCnt <= bitCnt + BIT_STEP;
      shiftReg <= rxByte;
    end else begin
      bitCnt <= 3'h0;
    end
  end

  // ********************************************************
  // Protocol state machine
  // ********************************************************
  always_comb begin
    next_state = state;
    if (startPending) begin
      next_state = ITCD_CTRL;
    end else if (stopPending) begin
      next_state = ITCD_IDLE;
    end else begin
      unique case (state)
        ITCD_IDLE: begin
          next_state = ITCD_IDLE;
        end
        ITCD_IGNORE: begin
          next_state = ITCD_IGNORE;
        end
        ITCD_CTRL: begin
          if (lastBit) begin
            if (codeMatch(rxByte, codeLink)) begin
              next_state = ITCD_CTRL_ACK;
            end else begin
              next_state = ITCD_IGNORE;
            end
          end
        end
        ITCD_CTRL_ACK: begin
          if (ctrlDir == DIR_READ) begin
            next_state = ITCD_RDATA;
          end else begin
            next_state = ITCD_WADDR;
          end
        end
        ITCD_WADDR: begin
          if (lastBit) begin
            next_state = ITCD_WADDR_ACK;
          end
        end
        ITCD_WADDR_ACK: begin
          next_state = ITCD_WDATA;
        end
        ITCD_WDATA: begin
          if (lastBit) begin
            next_state = ITCD_WDATA_ACK;
          end
        end
        ITCD_WDATA_ACK: begin
          // Further bytes without a stop form a page write.
          next_state = ITCD_WDATA;
        end
        ITCD_RDATA: begin
          if (lastBit) begin
            next_state = ITCD_RACK;
          end
        end
        ITCD_RACK: begin
          if (sdaIn == ACK_LEVEL) begin
            next_state = ITCD_RDATA;
          end else begin
            next_state = ITCD_IGNORE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      state <= ITCD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ********************************************************
  // Direction and address pointer
  // ********************************************************
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      ctrlDir <= 1'h0;
    end else if (!startPending && state == ITCD_CTRL && lastBit) begin
      ctrlDir <= rxByte[DIR_POS];
    end
  end

  // A repeated start only resets the state; the pointer loaded from the
  // word address stays for the read that follows.
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      ptr <= '0;
    end else if (startPending || stopPending) begin
      ptr <= ptr;
    end else if (state == ITCD_CTRL && lastBit && codeMatch(rxByte, codeLink)) begin
      ptr[PTR_BITS-1:WORD_BITS] <= rxByte[BLOCK_MSB:BLOCK_LSB];
    end else if (state == ITCD_WADDR && lastBit) begin
      ptr[WORD_BITS-1:0] <= rxByte;
    end else if ((state == ITCD_WDATA || state == ITCD_RDATA) && lastBit) begin
      // Sequential bytes wrap inside the block.
      ptr[WORD_BITS-1:0] <= ptr[WORD_BITS-1:0] + WORD_STEP;
    end
  end

  // ********************************************************
  // Byte store
  // ********************************************************
  // The byte is written on the edge that ends its last bit, so it is in
  // place by the time the acknowledge goes out, whatever follows.
  assign commitNow = !startPending && !stopPending &&
                     state == ITCD_WDATA && lastBit;

  assign storeBus.wrEn = commitNow;
  assign storeBus.wrPtr = ptr;
  assign storeBus.wrData = rxByte;
  assign storeBus.rdPtr = ptr;

  itcd_store storeInst (
    .sclClock(sclClock),
    .linkRst_n(linkRst_n),
    .port(storeBus)
  );

  // ********************************************************
  // Read data and line drive
  // ********************************************************
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      txByte <= '0;
    end else if (next_state == ITCD_RDATA && !inByte(state)) begin
      txByte <= storeBus.rdData;
    end
  end

  // Apart from the drop at a stop below, the line changes only while the bus clock is low, so the device can
  // never fake a start or stop of its own.
  always_ff @(negedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      oeReg <= 1'h0;
    end else if (inAckSlot(state)) begin
      oeReg <= 1'h1;
    end else if (state == ITCD_RDATA) begin
      oeReg <= ~txByte[LAST_BIT - bitCnt];
    end else begin
      oeReg <= 1'h0;
    end
  end

  // Open drain: the pin is only ever pulled low, and a stop drops the
  // pull at once even though no bus clock edge follows it.
  assign sdaOut = SDA_DRIVE_LEVEL;
  assign sdaOe = oeReg & ~stopPending;

  // ********************************************************
  // Commit report into the system clock domain
  // ********************************************************
  // Address and data are held steady in the link domain and a toggle
  // announces them; they stay valid until the next commit.
  always_ff @(posedge sclClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      commitTog <= 1'h0;
      holdPtr <= '0;
      holdData <= '0;
    end else if (commitNow) begin
      commitTog <= ~commitTog;
      holdPtr <= ptr;
      holdData <= rxByte;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commitSync <= 3'h0;
    end else begin
      commitSync <= {commitSync[1:0], commitTog};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commitPulse <= 1'h0;
      commitBlock <= '0;
      commitAddr <= '0;
      commitData <= '0;
    end else begin
      commitPulse <= commitSync[2] ^ commitSync[1];
      if (commitSync[2] ^ commitSync[1]) begin
        commitBlock <= holdPtr[PTR_BITS-1:WORD_BITS];
        commitAddr <= holdPtr[WORD_BITS-1:0];
        commitData <= holdData;
      end
    end
  end

endmodule : itcd_top

// ### dv/itcd_props.sv
`timescale 1ns/1ps
// ********
// Protocol checker.
// ********
module itcd_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclClock,
  input wire logic sdaIn,
  input wire logic sdaOe,
  input wire logic [itcd_pkg::CODE_BITS-1:0] controlCode,
  input wire logic commitPulse,
  input wire logic [itcd_pkg::BLOCK_BITS-1:0] commitBlock,
  input wire logic [itcd_pkg::WORD_BITS-1:0] commitData
);
  import itcd_pkg::*;
  logic startTog, seenTog, storeTog, storeSeen, dirRd, match;
  logic [3:0] bitCnt;
  logic [1:0] byteIdx;
  logic [2:0] blk, lastBlk;
  logic [7:0] shReg, lastData;
  wire logic newFrame = startTog != seenTog;
  wire logic [7:0] nextSh = {shReg[6:0], sdaIn};
  wire logic byteEnd = !newFrame && bitCnt == 4'h7;
  wire logic storeNow = byteEnd && byteIdx[1] && match && !dirRd;
  // A start is the only fall of data while the bus clock is high.
  always_ff @(negedge sdaIn or negedge rst_n) begin
    if (!rst_n) startTog <= 1'b0;
    else if (sclClock) startTog <= ~startTog;
  end
  always_ff @(posedge sclClock or negedge rst_n) begin
    if (!rst_n) begin
      seenTog <= 1'b0;
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
    end else begin
      seenTog <= startTog;
      bitCnt <= (newFrame || bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
      if (newFrame) byteIdx <= 2'h0;
      else if (bitCnt == 4'h9 && byteIdx != 2'h3) byteIdx <= byteIdx + 2'h1;
    end
  end
  always_ff @(posedge sclClock) begin
    shReg <= nextSh;
    if (byteEnd && byteIdx == 2'h0) begin
      dirRd <= sdaIn;
      blk <= shReg[2:0];
      match <= shReg[6:3] == controlCode;
    end
  end
  always_ff @(posedge sclClock or negedge rst_n) begin
    if (!rst_n) storeTog <= 1'b0;
    else if (storeNow) storeTog <= ~storeTog;
  end
  always_ff @(posedge sclClock) begin
    if (storeNow) begin
      lastData <= nextSh;
      lastBlk <= blk;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) storeSeen <= 1'b0;
    else storeSeen <= storeTog;
  end
  sequence s_ctrl_end;
    bitCnt == 4'h8 && byteIdx == 2'h0;
  endsequence
  property p_ack_match;
    @(negedge sclClock) disable iff (!rst_n) s_ctrl_end ##0 (shReg[7:4] == controlCode) |=> sdaOe;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("no ack on match");
  property p_nack_mismatch;
    @(negedge sclClock) disable iff (!rst_n)
      s_ctrl_end ##0 (shReg[7:4] != controlCode) |=> !sdaOe [*8];
  endproperty
  a_nack_mismatch: assert property (p_nack_mismatch) else $error("drive on mismatch");
  property p_ack_data;
    @(negedge sclClock) disable iff (!rst_n)
      bitCnt == 4'h8 && byteIdx != 2'h0 && match && !dirRd |=> sdaOe;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("no ack on write byte");
  property p_read_release;
    @(negedge sclClock) disable iff (!rst_n) bitCnt == 4'h8 && byteIdx != 2'h0 && dirRd |=> !sdaOe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("held master ack slot");
  property p_commit_cause;
    @(posedge clock) disable iff (!rst_n) storeTog != storeSeen |-> ##[1:4] commitPulse;
  endproperty
  a_commit_cause: assert property (p_commit_cause) else $error("store not reported");
  property p_commit_data;
    @(posedge clock) disable iff (!rst_n)
      $rose(commitPulse) |=> commitData == lastData && commitBlock == lastBlk;
  endproperty
  a_commit_data: assert property (p_commit_data) else $error("wrong stored byte");
  property p_commit_hold;
    @(posedge clock) disable iff (!rst_n) $changed(commitData) |-> commitPulse || $past(commitPulse);
  endproperty
  a_commit_hold: assert property (p_commit_hold) else $error("report not held");
  property p_commit_one;
    @(posedge clock) disable iff (!rst_n) commitPulse |=> !commitPulse;
  endproperty
  a_commit_one: assert property (p_commit_one) else $error("report too long");
endmodule : itcd_props
bind itcd_top itcd_props u_props (
  .clock,
  .rst_n,
  .sclClock,
  .sdaIn,
  .sdaOe,
  .controlCode,
  .commitPulse,
  .commitBlock,
  .commitData
);

// ### dv/itcd_master.sv
`timescale 1ns/1ps
// ********
// Bus master model; its clock stands high between frames.
// ********
module itcd_master (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaIn
);
  logic ackBit;
  logic [7:0] rdByte;
  event ackEv, byteEv;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Data moves only while the clock is low, so no false start or stop.
  task automatic clk1(input logic b, output logic got);
    #3.5 sdaDrv = b;
    #4 scl = 1'b1;
    got = sdaIn;
    #7.5 scl = 1'b0;
  endtask : clk1
  task automatic startC();
    if (!scl) begin
      #3.5 sdaDrv = 1'b1;
      #4 scl = 1'b1;
    end
    #4 sdaDrv = 1'b0;
    #4 scl = 1'b0;
  endtask : startC
  task automatic stopC();
    #3.5 sdaDrv = 1'b0;
    #4 scl = 1'b1;
    #4 sdaDrv = 1'b1;
  endtask : stopC
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk1(b[i], ackBit);
    clk1(1'b1, ackBit);
    ->ackEv;
  endtask : sendByte
  task automatic recvByte(input logic nack);
    logic g;
    for (int i = 7; i >= 0; i--) clk1(1'b1, rdByte[i]);
    ->byteEv;
    clk1(nack, g);
  endtask : recvByte
endmodule : itcd_master

// ### dv/itcd_top_tb.sv
`timescale 1ns/1ps
module itcd_top_tb;
  import itcd_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b1;
  logic [CODE_BITS-1:0] controlCode = CTRL_CODE_DEFAULT;
  logic sdaOut, sdaOe, commitPulse, scl, sdaDrv, dummy;
  logic [BLOCK_BITS-1:0] commitBlock;
  logic [WORD_BITS-1:0] commitAddr, commitData, a, d;
  wire logic sdaIn = (sdaOe === 1'b1) ? (sdaOut & sdaDrv) : sdaDrv;
  logic [7:0] nvm[256], vol[256];
  bit dirty[256];
  logic [18:0] expCommit[$];
  logic expAck[$];
  logic [7:0] expRd[$];
  int miscompares = 0;
  int cmp_count = 0;
  always #50 clock = ~clock;
  itcd_top dut (.clock, .rst_n, .sclClock(scl), .sdaIn, .sdaOut, .sdaOe, .controlCode,
    .commitPulse, .commitBlock, .commitAddr, .commitData);
  itcd_master m (.scl, .sdaDrv, .sdaIn);
  task automatic report(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : report
  task automatic cmpAck(input logic got, input logic exp);
    report(19'(got), 19'(exp));
  endtask : cmpAck
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    report(19'(got), 19'(exp));
  endtask : cmpByte
  task automatic cmpCommit(input logic [18:0] got, input logic [18:0] exp);
    report(got, exp);
  endtask : cmpCommit
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  function automatic logic [7:0] look(input logic [2:0] blk, input logic [7:0] adr);
    if (blk == BLOCK_NVM) return nvm[adr];
    if (blk == BLOCK_VOLATILE) return dirty[adr] ? vol[adr] : nvm[adr];
    return UNMAPPED_DATA;
  endfunction : look
  task automatic send(input logic [7:0] b, input logic ok);
    expAck.push_back(ok ? ACK_LEVEL : ~ACK_LEVEL);
    m.sendByte(b);
  endtask : send
  // Bytes are spaced by a long low clock so store reports never crowd.
  task automatic wr(input logic [3:0] code, input logic [2:0] blk, input logic [7:0] adr,
                    input logic [7:0] dat, input int n);
    logic ok;
    logic [7:0] p, v;
    ok = code === controlCode;
    m.startC();
    send({code, blk, ~DIR_READ}, ok);
    send(adr, ok);
    for (int i = 0; i < n; i++) begin
      p = adr + 8'(i);
      v = dat + 8'(i);
      if (ok) begin
        expCommit.push_back({blk, p, v});
        if (blk == BLOCK_NVM) nvm[p] = v;
        else vol[p] = v;
        dirty[p] |= blk == BLOCK_VOLATILE;
      end
      send(v, ok);
      #600;
    end
    m.stopC();
    #1500;
  endtask : wr
  // Without a word address the read starts at the pointer left by the last frame.
  task automatic rdCur(input logic [2:0] blk, input logic [7:0] adr, input int n);
    m.startC();
    send({controlCode, blk, DIR_READ}, 1'b1);
    for (int i = 0; i < n; i++) begin
      expRd.push_back(look(blk, adr + 8'(i)));
      m.recvByte(i == n - 1);
    end
    m.stopC();
    #1500;
  endtask : rdCur
  task automatic rd(input logic [2:0] blk, input logic [7:0] adr, input int n);
    m.startC();
    send({controlCode, blk, ~DIR_READ}, 1'b1);
    send(adr, 1'b1);
    rdCur(blk, adr, n);
  endtask : rd
  always @(negedge clock) begin
    if (commitPulse === 1'b1) begin
      cmpCommit({commitBlock, commitAddr, commitData},
        expCommit.size() ? expCommit.pop_front() : 'x);
    end
  end
  always @(m.ackEv) cmpAck(m.ackBit, expAck.size() ? expAck.pop_front() : 1'bx);
  always @(m.byteEv) cmpByte(m.rdByte, expRd.size() ? expRd.pop_front() : 8'hXX);
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h5E3B));
    // Reset falls at an edge, not in the initialiser, so every asynchronous
    // reset, the checker's included, sees it fall.
    @(negedge clock) rst_n = 1'b0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int r = 0; r < 3; r++) begin
      a = 8'($urandom);
      d = 8'($urandom);
      wr(controlCode, BLOCK_NVM, a, d, 2);
      wr(controlCode, BLOCK_VOLATILE, a + 8'h01, ~d, 1);
      rd(BLOCK_NVM, a, 2);
      rd(BLOCK_VOLATILE, a, 2);
      rd(3'h5, a, 1);
      wr(controlCode ^ 4'h8, BLOCK_VOLATILE, a, d, 1);
      // A stop in mid-byte must leave nothing stored and the line free.
      m.startC();
      send({controlCode, BLOCK_VOLATILE, ~DIR_READ}, 1'b1);
      send(a, 1'b1);
      repeat (3) m.clk1(1'b0, dummy);
      m.stopC();
      #20 cmpAck(sdaOe, 1'b0);
      // The cut frame left the pointer at a; the block comes from this control byte.
      rdCur(BLOCK_NVM, a, 1);
      rd(BLOCK_VOLATILE, a, 1);
      @(negedge clock) rst_n = 1'b0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      dirty = '{default: 1'b0};
      repeat (4) @(negedge clock);
      rd(BLOCK_VOLATILE, a + 8'h01, 1);
      @(negedge clock) controlCode = 4'($urandom);
      repeat (2) @(negedge clock);
    end
    #2000;
    cmpCommit(19'(expCommit.size()), 19'h0);
    tally_and_finish();
  end
endmodule : itcd_top_tb
